/* rtl/epc_consts.svh */
/*
 Timing counts and pin-level constants for the memory programming host.
 Assumes a 25 MHz system clock; included by bare name.
*/
`ifndef EPC_CONSTS_SVH
`define EPC_CONSTS_SVH
`define EPC_CLK_NS     40
`define EPC_LEAD_US    2
`define EPC_LEAD_CYC   ((`EPC_LEAD_US * 1000 + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_VERIFY_NS  55
`define EPC_VERIFY_CYC ((`EPC_VERIFY_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS + 1)
`define EPC_FLOAT_NS   55
`define EPC_FLOAT_CYC  ((`EPC_FLOAT_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_PULSE_US   3000
`define EPC_READ_NS    200
`define EPC_READ_CYC   ((`EPC_READ_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS + 1)
`define EPC_ADDR_W     17
`endif

/* rtl/epc_host.sv */
/*
 Host controller that reads, programs and identifies a UV-erasable
 128K x 8 memory through its pins. Assumes external level shifters turn
 the supply and high-voltage enables into the programming voltages, and
 that all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "epc_consts.svh"

// What this block does
// - Identifier read: low address bits held low, line zero picks code.
// - Identifier read raises address line nine to high voltage.
// - Supply raised and select low 2 us before strobe falls.
// - Wait 2 us after strobe rises before gate goes low.
// - Gate may lag select by select minus gate access time.
// - Supply never switches while select and strobe are both low.
// - Strobe is high from reset, before the supply is raised.
module epc_host #(
    parameter int PULSE_CYC = `EPC_PULSE_US * 1000 / `EPC_CLK_NS
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   reqValid,
    output logic                        reqReady,
    input  wire epc_pkg::epc_op_type    reqOp,
    input  wire logic [`EPC_ADDR_W-1:0] reqAddr,
    input  wire logic [7:0]             reqData,
    output logic                        rspValid,
    output logic [7:0]                  rspData,
    output logic                        rspMatch,
    output logic [`EPC_ADDR_W-1:0]      memAddr,
    output logic                        chipSelect_n,
    output logic                        outputGate_n,
    output logic                        program_strobe_n,
    output logic                        progSupplyOn,
    output logic                        address_line_nine_hv,
    input  wire logic [7:0]             memDataIn,
    output logic [7:0]                  memDataOut,
    output logic                        memDataOe_n
);
    // The counter is 20 bits wide and a zero count would wrap to its top.
    if (PULSE_CYC < 1 || PULSE_CYC >= (1 << 20)) begin : g_pulseRange
        $error("PULSE_CYC out of range");
    end

    epc_pkg::epc_state_type stateReg, stateNext;
    epc_pkg::epc_op_type    opReg, opNext;
    logic [19:0]            cntReg, cntNext;
    logic [`EPC_ADDR_W-1:0] addrReg, addrNext;
    logic [7:0] wdReg, wdNext, rdReg, rdNext;
    logic ceReg, ceNext, oeReg, oeNext, pgReg, pgNext;
    logic vppReg, vppNext, hvReg, hvNext, drvReg, drvNext;
    logic rvReg, rvNext, mtReg, mtNext;
    logic [19:0]            lowCntReg, lowCntNext;

    default clocking epcCb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    function automatic logic [19:0] cyc(input int n);
        cyc = 20'(n - 1);
    endfunction : cyc

    always_comb begin
        stateNext = stateReg;
        opNext = opReg;
        cntNext = (cntReg != 20'h0) ? cntReg - 20'h1 : 20'h0;
        addrNext = addrReg;
        wdNext = wdReg;
        rdNext = rdReg;
        ceNext = ceReg;
        oeNext = oeReg;
        pgNext = pgReg;
        vppNext = vppReg;
        hvNext = hvReg;
        drvNext = drvReg;
        rvNext = 1'b0;
        mtNext = mtReg;
        unique case (stateReg)
            epc_pkg::EPC_IDLE: begin
                if (reqValid) begin
                    opNext = reqOp;
                    wdNext = reqData;
                    ceNext = 1'b0;
                    if (reqOp == epc_pkg::EPC_OP_IDENT) begin
                        // Only line zero survives; the rest stay low. 
                        addrNext = {{(`EPC_ADDR_W-1){1'b0}},
                                    reqAddr[0]};
                        hvNext = 1'b1;
                    end else begin
                        addrNext = reqAddr;
                    end
                    if (reqOp == epc_pkg::EPC_OP_PROG) begin
                        vppNext = 1'b1;
                        drvNext = 1'b1;
                        cntNext = cyc(`EPC_LEAD_CYC);
                        stateNext = epc_pkg::EPC_SETUP;
                    end else begin
                        // Gate together with select keeps within the lag
                        // allowance, so access stays at select time.
                        oeNext = 1'b0;
                        cntNext = cyc(`EPC_READ_CYC);
                        stateNext = epc_pkg::EPC_SAMPLE;
                    end
                end
            end
            epc_pkg::EPC_SETUP: begin
                if (cntReg == 20'h0) begin
                    pgNext = 1'b0;
                    cntNext = cyc(PULSE_CYC);
                    stateNext = epc_pkg::EPC_PULSE;
                end
            end
            epc_pkg::EPC_PULSE: begin
                if (cntReg == 20'h0) begin
                    pgNext = 1'b1;
                    cntNext = cyc(`EPC_LEAD_CYC);
                    stateNext = epc_pkg::EPC_RECOV;
                end
            end
            epc_pkg::EPC_RECOV: begin
                drvNext = 1'b0;
                if (cntReg == 20'h0) begin
                    oeNext = 1'b0;
                    cntNext = cyc(`EPC_VERIFY_CYC);
                    stateNext = epc_pkg::EPC_SAMPLE;
                end
            end
            epc_pkg::EPC_SAMPLE: begin
                if (cntReg == 20'h0) begin
                    rdNext = memDataIn;
                    mtNext = (memDataIn == wdReg);
                    ceNext = 1'b1;
                    oeNext = 1'b1;
                    hvNext = 1'b0;
                    cntNext = cyc(`EPC_FLOAT_CYC);
                    stateNext = epc_pkg::EPC_FLOAT;
                end
            end
            epc_pkg::EPC_FLOAT: begin
                // Supply drops only once select is high again.
                if (cntReg == 20'h0) begin
                    vppNext = 1'b0;
                    stateNext = epc_pkg::EPC_DONE;
                end
            end
            epc_pkg::EPC_DONE: begin
                rvNext = 1'b1;
                stateNext = epc_pkg::EPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stateReg <= epc_pkg::EPC_IDLE;
            opReg <= epc_pkg::EPC_OP_READ;
            cntReg <= 20'h0;
            addrReg <= '0;
            wdReg <= 8'h00;
            rdReg <= 8'h00;
            ceReg <= 1'b1;
            oeReg <= 1'b1;
            pgReg <= 1'b1;
            vppReg <= 1'b0;
            hvReg <= 1'b0;
            drvReg <= 1'b0;
            rvReg <= 1'b0;
            mtReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            opReg <= opNext;
            cntReg <= cntNext;
            addrReg <= addrNext;
            wdReg <= wdNext;
            rdReg <= rdNext;
            ceReg <= ceNext;
            oeReg <= oeNext;
            pgReg <= pgNext;
            vppReg <= vppNext;
            hvReg <= hvNext;
            drvReg <= drvNext;
            rvReg <= rvNext;
            mtReg <= mtNext;
        end
    end

    assign reqReady = (stateReg == epc_pkg::EPC_IDLE);
    assign rspValid = rvReg;
    assign rspData = rdReg;
    assign rspMatch = mtReg;
    assign memAddr = addrReg;
    assign chipSelect_n = ceReg;
    assign outputGate_n = oeReg;
    assign program_strobe_n = pgReg;
    assign progSupplyOn = vppReg;
    assign address_line_nine_hv = hvReg;
    assign memDataOut = wdReg;
    // Host drives data only while the memory's gate is high.
    assign memDataOe_n = !(drvReg && oeReg);

    localparam int LEAD_C = `EPC_LEAD_CYC;

    // Counts strobe-low cycles so that the pulse width is checked exactly.
    always_comb begin
        lowCntNext = program_strobe_n ? 20'h0 : lowCntReg + 20'h1;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            lowCntReg <= 20'h0;
        end else begin
            lowCntReg <= lowCntNext;
        end
    end

    sequence supplyReady_s;
        progSupplyOn && !chipSelect_n && program_strobe_n;
    endsequence

    strobe_lead_a: assert property (
        $fell(program_strobe_n) |-> $past(progSupplyOn, LEAD_C)
            && $past(!chipSelect_n, LEAD_C))
        else $error("strobe fell without supply and select lead");
    strobe_setup_a: assert property (
        $rose(progSupplyOn) |-> supplyReady_s [*8])
        else $error("supply setup not held");
    gate_lead_a: assert property (
        $fell(outputGate_n) && opReg == epc_pkg::EPC_OP_PROG
            |-> $past(program_strobe_n, LEAD_C))
        else $error("gate fell too soon after strobe");
    supply_steady_a: assert property (
        (!chipSelect_n && !program_strobe_n) |-> $stable(progSupplyOn))
        else $error("supply switched during pulse");
    strobe_idle_a: assert property (
        !progSupplyOn |-> program_strobe_n)
        else $error("strobe low without supply");
    pulse_width_a: assert property (
        $rose(program_strobe_n) |-> $past(!program_strobe_n, 2)
            && (lowCntReg == 20'(PULSE_CYC))
            && (cntReg == 20'(LEAD_C - 1)))
        else $error("pulse width or recovery wrong");
    ident_low_a: assert property (
        address_line_nine_hv |-> memAddr[`EPC_ADDR_W-1:1] == '0)
        else $error("identifier address not low");
    no_clash_a: assert property (
        !outputGate_n |-> memDataOe_n)
        else $error("host drives while memory may drive");
    float_wait_a: assert property (
        $rose(chipSelect_n) |-> !rspValid [*2])
        else $error("answer before release");
endmodule : epc_host
`default_nettype wire

/* rtl/epc_pkg.sv */
/*
 Types for the memory programming host.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package epc_pkg;
    typedef enum logic [1:0] {
        EPC_OP_READ  = 2'h0,
        EPC_OP_PROG  = 2'h1,
        EPC_OP_IDENT = 2'h2
    } epc_op_type;
    typedef enum logic [6:0] {
        EPC_IDLE   = 7'h01,
        EPC_SETUP  = 7'h02,
        EPC_PULSE  = 7'h04,
        EPC_RECOV  = 7'h08,
        EPC_SAMPLE = 7'h10,
        EPC_FLOAT  = 7'h20,
        EPC_DONE   = 7'h40
    } epc_state_type;
endpackage : epc_pkg
`default_nettype wire

/* verif/epc_mem_model.sv */
/*
 Behavioural model of the UV-erasable memory seen at the host's pins.
 Assumes the host's data driver and this model are the only bus parties.
*/
`timescale 1ns/1ps
`default_nettype none
module epc_mem_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value.
    parameter logic [7:0] PART_CODE  = 8'ha5  // Arbitrary value.
) (
    input  wire logic [16:0] addr,
    input  wire logic        chipSelect_n,
    input  wire logic        outputGate_n,
    input  wire logic        program_strobe_n,
    input  wire logic        progSupplyOn,
    input  wire logic        address_line_nine_hv,
    input  wire logic [7:0]  hostData,
    input  wire logic        hostOe_n,
    input  wire logic        slow,
    output logic [7:0]       busData
);
    logic [7:0] mem [0:131071];
    logic [7:0] devVal;
    logic [7:0] lateVal;
    logic [7:0] shown;
    logic [7:0] lastVal;
    logic       drives;
    logic       holdOn;
    logic       drvNow;
    initial begin
        for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
        lastVal = 8'h00;
    end
    // Signature only with every address line but zero and nine low.
    assign devVal = (address_line_nine_hv && (addr[16:1] & 16'hfeff) == 16'h0)
                    ? (addr[0] ? PART_CODE : MAKER_CODE)
                    : mem[addr];
    assign drives = !chipSelect_n && !outputGate_n;
    // The slow corner still lands inside the 55 ns figures.
    assign #50 lateVal = devVal;
    assign #40 holdOn = drives;
    assign shown = slow ? lateVal : devVal;
    assign drvNow = slow ? (drives || holdOn) : drives;
    always @* if (drvNow) lastVal = shown;
    // A released bus shows the inverse so stale data cannot pass.
    assign busData = !hostOe_n ? hostData : (drvNow ? shown : ~lastVal);
    // Programming can only clear bits, as in a real cell. The byte is taken
    // from the shared bus, so a host that stops driving early is caught.
    always @(posedge program_strobe_n) begin
        if (!chipSelect_n && progSupplyOn && outputGate_n) begin
            mem[addr] = mem[addr] & busData;
        end
    end
endmodule : epc_mem_model
`default_nettype wire

/* verif/tb_eprom_mode_and_program_port.sv */
/*
 Self-checking bench for the memory programming host with a memory model.
 Assumes a shortened strobe pulse of PULSE cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_eprom_mode_and_program_port;
    localparam int PULSE = 20;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value.
    localparam logic [7:0] PART = 8'hc3;  // Arbitrary value.
    logic clk, nrst, reqValid, reqReady, rspValid, rspMatch, slow;
    logic chipSelect_n, outputGate_n, program_strobe_n;
    logic progSupplyOn, hvOn, oeN;
    epc_pkg::epc_op_type reqOp;
    logic [16:0] reqAddr, memAddr, a;
    logic [7:0] reqData, rspData, memDataIn, memDataOut, seed, rv;
    logic [7:0] refMem [0:131071];
    int err_total, tests_run;
    realtime tSel, tUp, tDn;
    epc_host #(.PULSE_CYC(PULSE)) i_dut (.clk(clk), .nrst(nrst),
        .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
        .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid),
        .rspData(rspData), .rspMatch(rspMatch), .memAddr(memAddr),
        .chipSelect_n(chipSelect_n), .outputGate_n(outputGate_n),
        .program_strobe_n(program_strobe_n), .progSupplyOn(progSupplyOn),
        .address_line_nine_hv(hvOn), .memDataIn(memDataIn),
        .memDataOut(memDataOut), .memDataOe_n(oeN));
    epc_mem_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_mem (
        .addr(memAddr),
        .chipSelect_n(chipSelect_n), .outputGate_n(outputGate_n),
        .program_strobe_n(program_strobe_n), .progSupplyOn(progSupplyOn),
        .address_line_nine_hv(hvOn), .hostData(memDataOut), .hostOe_n(oeN),
        .slow(slow), .busData(memDataIn));
    always #20 clk = ~clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chkData(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chkData
    task automatic chkFlag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chkFlag
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    // Reset may fall at any idle point; the array contents must survive it.
    task automatic resetPulse();
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        chkFlag(program_strobe_n, 1'b1);
        chkFlag(progSupplyOn, 1'b0);
        chkFlag(chipSelect_n & reqReady & !rspValid & oeN, 1'b1);
    endtask : resetPulse
    // Pin spacing is judged in real time so edge alignment cannot hide it.
    always @(negedge chipSelect_n or posedge progSupplyOn) tSel = $realtime;
    always @(posedge program_strobe_n) begin
        tUp = $realtime;
        if (nrst === 1'b1) begin
            chkFlag($realtime - tDn == PULSE * 40.0, 1'b1);
        end
    end
    always @(negedge program_strobe_n) begin
        tDn = $realtime;
        if (nrst === 1'b1) begin
            chkFlag($realtime - tSel >= 2000.0, 1'b1);
        end
    end
    always @(negedge outputGate_n) begin
        if (progSupplyOn === 1'b1) begin
            chkFlag($realtime - tUp >= 2000.0, 1'b1);
        end
    end
    always @(progSupplyOn) begin
        if (nrst === 1'b1) begin
            chkFlag(!chipSelect_n && !program_strobe_n, 1'b0);
        end
    end
    task automatic op(input epc_pkg::epc_op_type o, input logic [7:0] d);
        int n;
        @(negedge clk);
        reqOp = o;
        reqAddr = a;
        reqData = d;
        reqValid = 1'b1;
        @(negedge clk);
        reqValid = 1'b0;
        chkFlag(reqReady, 1'b0);
        n = 0;
        while (rspValid !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n == 400) begin
            err_total++;
            results();
        end else begin
            rv = refMem[a];
            if (o == epc_pkg::EPC_OP_READ) begin
                chkData(rspData, rv);
            end
            if (o == epc_pkg::EPC_OP_IDENT) begin
                chkData(rspData, a[0] ? PART : MAKER);
            end
            if (o == epc_pkg::EPC_OP_PROG) begin
                refMem[a] = rv & d;
                chkData(rspData, rv & d);
                chkFlag(rspMatch, (rv & d) == d);
            end
        end
    endtask : op
    initial begin
        clk = 1'b0;
        reqValid = 1'b0;
        reqOp = epc_pkg::EPC_OP_READ;
        reqAddr = 17'h00000;
        reqData = 8'h00;
        slow = 1'b0;
        seed = 8'h2e;
        for (int j = 0; j < 131072; j++) begin
            refMem[j] = 8'hff;
        end
        resetPulse();
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            slow = seed[3];
            a = {seed[7], 14'h0000, seed[1:0]};
            op(epc_pkg::EPC_OP_PROG, lfsr(seed));
            op(epc_pkg::EPC_OP_READ, 8'h00);
            op(epc_pkg::EPC_OP_IDENT, 8'h00);
            if (i == 6) begin
                resetPulse();
            end
            chkFlag(oeN & chipSelect_n & outputGate_n & !hvOn, 1'b1);
            $display("test %0d done", i);
        end
        results();
    end
endmodule : tb_eprom_mode_and_program_port
`default_nettype wire
